// *** pkg/fkpe_cfg.svh ***
// Purpose: constants of the flash key and sequencer block
// Assumes: byte-wide core data, byte-wide flash
// Notes:   timing counts derive from the 100 MHz system clock
`ifndef FKPE_CFG_SVH
`define FKPE_CFG_SVH
`define FKPE_KEY_FIRST   8'hA5
`define FKPE_KEY_SECOND  8'hF1
`define FKPE_ERASED_BYTE 8'hFF
`define FKPE_ARMED_BIT   2
`define FKPE_LOCKED_BIT  3
`define FKPE_CLK_MHZ     100
`define FKPE_PROG_US     10
`define FKPE_ERASE_US    40
`define FKPE_PROG_CYC    (`FKPE_PROG_US * `FKPE_CLK_MHZ)
`define FKPE_ERASE_CYC   (`FKPE_ERASE_US * `FKPE_CLK_MHZ)
`endif

// *** pkg/fkpe_pkg.sv ***
// Purpose: types of the flash key and sequencer block
// Assumes: included config header holds the numbers
// Notes:   one-hot state codes
package fkpe_pkg;
    typedef enum logic [3:0] {
        FKPE_KEY_IDLE   = 4'h1,
        FKPE_KEY_FIRST  = 4'h2,
        FKPE_KEY_ARMED  = 4'h4,
        FKPE_KEY_LOCKED = 4'h8
    } fkpe_key_type;
    typedef enum logic [2:0] {
        FKPE_OP_IDLE  = 3'h1,
        FKPE_OP_PROG  = 3'h2,
        FKPE_OP_ERASE = 3'h4
    } fkpe_op_type;
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } fkpe_wr_type;
endpackage

// *** rtl/fkpe_flash_seq.sv ***
// Purpose: lock and key guarded flash program and erase sequencer
// Assumes: core write strobes are synchronous to clk_sys_i
// Notes:   flash array is modelled inside; page address is upper bits
`include "fkpe_cfg.svh"

// Summary of operation
// - Programming a byte only clears bits, by ANDing data into the cell.
// - Erase sets every byte of the addressed page to 0xFF.
// - Each operation is timed internally by a cycle counter to its end.
// - A stall output holds the core while an operation runs.
// - Arming needs key 0xA5 then 0xF1, with any gap between them.
// - A wrong or out-of-order key locks out operations until reset.
// - A flash write attempted before arming also locks out until reset.
// - When each operation starts the key returns to locked idle.
// - With write enable set, external-move writes go to flash.
// - Write enable holds across operations; only software or reset clear.
// - Erase enable plus write enable plus armed key erases the page.
// - Write enable with erase enable clear programs the data byte.
// - With write enable clear, writes go to the external data RAM.
module fkpe_flash_seq
    import fkpe_pkg::*;
#(
    parameter int ADDR_W    = 13,
    parameter int PAGE_W    = 9,
    parameter int PROG_CYC  = `FKPE_PROG_CYC,
    parameter int ERASE_CYC = `FKPE_ERASE_CYC
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_b_i,
    input  wire logic              key_wr_i,
    input  wire logic [7:0]        key_data_i,
    input  wire logic              ctl_wr_i,
    input  wire logic              ctl_we_i,
    input  wire logic              ctl_ee_i,
    input  wire fkpe_wr_type       xmove_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic                   store_write_enable_o,
    output logic                   store_erase_enable_o,
    output logic                   stall_o,
    output logic                   locked_out_o,
    output logic                   armed_o,
    output fkpe_wr_type            ram_wr_o,
    output logic [7:0]             rd_data_o
);
    localparam int PSIZE = 1 << PAGE_W;

    logic [7:0]         mem_ff [(1<<ADDR_W)];
    fkpe_key_type       key_ff, nxt_key;
    fkpe_op_type        op_ff, nxt_op;
    logic               we_ff, nxt_we;
    logic               ee_ff, nxt_ee;
    logic [31:0]        cnt_ff, nxt_cnt;
    logic [ADDR_W-1:0]  adr_ff, nxt_adr;
    logic [7:0]         dat_ff, nxt_dat;
    fkpe_wr_type        ram_ff, nxt_ram;
    logic               stall_ff, nxt_stall;
    logic [31:0]        busy_run_ff, nxt_run;
    logic [7:0]         rd_ff;
    logic               flash_wr;
    logic               done;

    assign flash_wr = xmove_i.valid && we_ff && (op_ff == FKPE_OP_IDLE);
    assign done     = (op_ff != FKPE_OP_IDLE) && (cnt_ff == 32'h0000_0001);

    always_comb begin
        nxt_we   = we_ff;
        nxt_ee   = ee_ff;
        nxt_key  = key_ff;
        nxt_op   = op_ff;
        nxt_cnt  = cnt_ff;
        nxt_adr  = adr_ff;
        nxt_dat  = dat_ff;
        nxt_ram  = '0;
        if (ctl_wr_i) begin
            nxt_we = ctl_we_i;
            nxt_ee = ctl_ee_i;
        end
        case (key_ff)
            FKPE_KEY_IDLE: begin
                if (key_wr_i) begin
                    nxt_key = (key_data_i == `FKPE_KEY_FIRST) ?
                              FKPE_KEY_FIRST : FKPE_KEY_LOCKED;
                end
            end
            FKPE_KEY_FIRST: begin
                if (key_wr_i) begin
                    nxt_key = (key_data_i == `FKPE_KEY_SECOND) ?
                              FKPE_KEY_ARMED : FKPE_KEY_LOCKED;
                end
            end
            FKPE_KEY_ARMED: begin
                if (key_wr_i) begin
                    nxt_key = FKPE_KEY_LOCKED;
                end
            end
            FKPE_KEY_LOCKED: begin
                nxt_key = FKPE_KEY_LOCKED;
            end
            default: begin
                nxt_key = FKPE_KEY_LOCKED;
            end
        endcase
        if (flash_wr) begin
            if (key_ff == FKPE_KEY_ARMED && !key_wr_i) begin
                nxt_adr = xmove_i.addr[ADDR_W-1:0];
                nxt_dat = xmove_i.data;
                nxt_op  = ee_ff ? FKPE_OP_ERASE : FKPE_OP_PROG;
                nxt_cnt = ee_ff ? ERASE_CYC : PROG_CYC;
                nxt_key = FKPE_KEY_IDLE;
            end else begin
                nxt_key = FKPE_KEY_LOCKED;
            end
        end else if (xmove_i.valid && !we_ff) begin
            nxt_ram = xmove_i;
        end
        if (op_ff != FKPE_OP_IDLE) begin
            nxt_cnt = cnt_ff - 32'h0000_0001;
            if (done) begin
                nxt_op = FKPE_OP_IDLE;
            end
        end
        // Registered so the stall pin has no decode glitch
        nxt_stall = (nxt_op != FKPE_OP_IDLE);
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            key_ff  <= FKPE_KEY_IDLE;
            op_ff   <= FKPE_OP_IDLE;
            we_ff   <= 1'b0;
            ee_ff   <= 1'b0;
            cnt_ff  <= '0;
            adr_ff  <= '0;
            dat_ff  <= '0;
            ram_ff  <= '0;
            stall_ff <= 1'b0;
        end else begin
            key_ff  <= nxt_key;
            op_ff   <= nxt_op;
            we_ff   <= nxt_we;
            ee_ff   <= nxt_ee;
            cnt_ff  <= nxt_cnt;
            adr_ff  <= nxt_adr;
            dat_ff  <= nxt_dat;
            ram_ff  <= nxt_ram;
            stall_ff <= nxt_stall;
        end
    end

    // Array commits at the end so a stalled core sees old data until done
    always_ff @(posedge clk_sys_i) begin
        if (done && op_ff == FKPE_OP_PROG) begin
            mem_ff[adr_ff] <= mem_ff[adr_ff] & dat_ff;
        end
        if (done && op_ff == FKPE_OP_ERASE) begin
            for (int i = 0; i < PSIZE; i++) begin
                mem_ff[{adr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <=
                    `FKPE_ERASED_BYTE;
            end
        end
        rd_ff <= mem_ff[rd_addr_i];
    end

    assign store_write_enable_o = we_ff;
    assign store_erase_enable_o = ee_ff;
    assign stall_o      = stall_ff;
    // One-hot codes let the flags come straight from the state bits
    assign locked_out_o = key_ff[`FKPE_LOCKED_BIT];
    assign armed_o      = key_ff[`FKPE_ARMED_BIT];
    assign ram_wr_o     = ram_ff;
    assign rd_data_o    = rd_ff;

    // Stall run length, kept only for the length check
    always_comb begin
        nxt_run = stall_ff ? busy_run_ff + 32'h0000_0001 : '0;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_run_ff <= '0;
        end else begin
            busy_run_ff <= nxt_run;
        end
    end

    chk_busy_len: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) $fell(stall_o) |-> busy_run_ff ==
        (($past(op_ff) == FKPE_OP_PROG) ? PROG_CYC : ERASE_CYC))
        else $error("operation length wrong");
    chk_prog_clear: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) done && op_ff == FKPE_OP_PROG
        |=> (mem_ff[$past(adr_ff)] & ~$past(mem_ff[adr_ff])) == 8'h00)
        else $error("program set a bit");
    chk_lock_sticky: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) locked_out_o |=> locked_out_o)
        else $error("lockout left without reset");
    chk_early_lock: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) flash_wr && !armed_o |=> locked_out_o)
        else $error("early write did not lock");
    chk_relock_after: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) flash_wr && armed_o && !key_wr_i
        |=> !armed_o && stall_o)
        else $error("key not relocked");
    chk_key_order: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) $rose(armed_o) |->
        $past(key_ff) == FKPE_KEY_FIRST && $past(key_wr_i) &&
        $past(key_data_i) == `FKPE_KEY_SECOND)
        else $error("armed without key order");
    chk_ram_route: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) xmove_i.valid && !we_ff |=> ram_wr_o.valid)
        else $error("ram write lost");
    chk_flash_route: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) we_ff |=> !ram_wr_o.valid)
        else $error("flash write leaked to ram");
    chk_we_hold: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) !ctl_wr_i |=> we_ff == $past(we_ff))
        else $error("write enable changed");
    chk_erase_select: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) flash_wr && armed_o && !key_wr_i && ee_ff
        |=> op_ff == FKPE_OP_ERASE)
        else $error("erase not started");
endmodule

// *** testbench/fkpe_core_model.sv ***
// Purpose: core side model issuing key, control and move writes
// Assumes: one write per call, then one idle cycle
// Notes:   callers choose the codes, so bad key orders come from the bench
module fkpe_core_model
    import fkpe_pkg::*;
(
    input  wire logic  clk_i,
    output logic       key_wr_o,
    output logic [7:0] key_data_o,
    output logic       ctl_wr_o,
    output logic       we_o,
    output logic       ee_o,
    output fkpe_wr_type mv_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {key_wr_o, key_data_o, ctl_wr_o, we_o, ee_o} = '0;
        mv_o = '0;
    end
    // one call at a time, so nothing splits a sequence
    // codes leave in the order given
    task automatic key(input logic [7:0] d);
        @(posedge clk_i) {key_wr_o, key_data_o} <= {1'b1, d};
        @(posedge clk_i) key_wr_o <= 1'b0;
    endtask
    // zeros drop both enables before the RAM route test
    task automatic ctl(input logic w, input logic e);
        @(posedge clk_i) {ctl_wr_o, we_o, ee_o} <= {1'b1, w, e};
        @(posedge clk_i) ctl_wr_o <= 1'b0;
    endtask
    task automatic mv(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i) mv_o <= {1'b1, a, d};
        @(posedge clk_i) mv_o.valid <= 1'b0;
    endtask
endmodule

// *** testbench/flash_key_program_erase_bench.sv ***
// Purpose: self-checking bench of the flash key sequencer
// Assumes: short program and erase counts keep the run brief
// Notes:   reads and RAM writes are judged through a note queue
module flash_key_program_erase_bench
    import fkpe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PROG_CYC = 4;
    localparam int ERASE_CYC = 8;
    logic        clk = 1'b0, rst_b = 1'b0, rd_go = 1'b0, rd_d = 1'b0;
    logic        kw, cw, we, ee, swe, see, stall, lock, armed;
    logic [7:0]  kd, rd_data, d1, d2;
    logic [12:0] rd_addr = '0;
    logic [15:0] a;
    fkpe_wr_type mv, ram_wr;
    logic [24:0] notes[$], got;
    int          n_fail = 0, comparisons = 0, n;
    always #5 clk = ~clk;
    fkpe_core_model core (.clk_i(clk), .key_wr_o(kw), .key_data_o(kd),
        .ctl_wr_o(cw), .we_o(we), .ee_o(ee), .mv_o(mv));
    fkpe_flash_seq #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) uut (
        .clk_sys_i(clk), .rst_b_i(rst_b), .key_wr_i(kw), .key_data_i(kd),
        .ctl_wr_i(cw), .ctl_we_i(we), .ctl_ee_i(ee), .xmove_i(mv),
        .rd_addr_i(rd_addr), .store_write_enable_o(swe),
        .store_erase_enable_o(see), .stall_o(stall), .locked_out_o(lock),
        .armed_o(armed), .ram_wr_o(ram_wr), .rd_data_o(rd_data));
    task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Read data lands one cycle after the address is taken
    always @(posedge clk) rd_d <= rd_go;
    always @(negedge clk) begin
        if (rd_d || ram_wr.valid === 1'b1) begin
            got = rd_d ? {17'h0, rd_data} : ram_wr;
            // A result nobody expected meets an unknown note and mismatches
            if (notes.size() == 0) chk(got, 'x);
            else chk(got, notes.pop_front());
        end
    end
    task automatic rd(input logic [15:0] ad, input logic [7:0] e);
        notes.push_back({17'h0, e});
        @(posedge clk) {rd_addr, rd_go} <= {ad[12:0], 1'b1};
        @(posedge clk) rd_go <= 1'b0;
    endtask
    task automatic unlock;
        core.key(8'hA5);
        core.key(8'hF1);
        @(negedge clk);
        chk(armed, 1'b1);
    endtask
    // Counts stall cycles; a refused write shows none
    task automatic op(input logic [15:0] ad, input logic [7:0] d, int len);
        core.mv(ad, d);
        n = 0;
        do begin @(negedge clk); n++; end while (stall !== 1'b1 && n < 4);
        n = 0;
        while (stall === 1'b1 && n < 100) begin @(negedge clk); n++; end
        chk(25'(n), 25'(len));
        chk(armed, 1'b0);
    endtask
    initial begin
        #100000;
        n_fail++;
        results;
    end
    initial begin
        void'($urandom(94770));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        core.ctl(1'b1, 1'b1);
        unlock;
        // the page is erased before a byte in it is programmed
        op(16'h0433, 8'($urandom), ERASE_CYC);
        chk(see, 1'b1);
        rd(16'h0400, 8'hFF);
        rd(16'h05FF, 8'hFF);
        core.ctl(1'b1, 1'b0);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        unlock;
        op(16'h0455, d1, PROG_CYC);
        chk(swe, 1'b1);
        rd(16'h0455, d1);
        unlock;
        op(16'h0455, d2, PROG_CYC);
        rd(16'h0455, d1 & d2);
        $display("erase and program test done");
        core.ctl(1'b0, 1'b0);
        a = 16'($urandom);
        notes.push_back({1'b1, a, d2});
        core.mv(a, d2);
        repeat (4) @(posedge clk);
        $display("ram route test done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) rst_b <= 1'b0;
            repeat (2) @(posedge clk);
            rst_b <= 1'b1;
            @(negedge clk);
            chk(swe, 1'b0);
            chk(see, 1'b0);
            core.ctl(1'b1, 1'b0);
            if (i > 0) core.key(i == 1 ? 8'hF1 : 8'hA5);
            if (i == 2) core.key(8'h00);
            op(16'h0455, 8'h00, 0);
            chk(lock, 1'b1);
            core.key(8'hA5);
            core.key(8'hF1);
            op(16'h0455, 8'h00, 0);
        end
        $display("lockout test done");
        repeat (4) @(posedge clk);
        results;
    end
endmodule
